/* uarx_recovery.sv */
// receive clock and data recovery with frame buffer
`default_nettype none
// Summary of operation
// - sample line 16 times per bit, or 8 in double speed
// - idle high to low edge starts detection, first low is sample one
// - start validated on samples 8,9,10 or 4,5,6 in double speed
// - two or more high validation samples reject start as noise
// - valid start realigns bit timing, repeated every frame
// - sixteen or eight sample states per bit, sample number equals state
// - bit is majority of three centre samples
// - first vote sample 8 or 4, middle 9 or 5
// - recover up to first stop bit, later stop bits ignored
// - stop bit voted the same way, zero sets frame error flag
// - normal mode accepts next start right after last stop vote sample
// - frame error stored with its frame, cleared by good stop bit
module uarx_recovery #(
  parameter int unsigned DATA_BITS = 8,
  parameter int unsigned DEPTH     = uarx_pkg::FIFO_DEPTH
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire logic                 sample_tick,
  input  wire logic                 double_speed_select,
  input  wire logic                 serial_in,
  input  wire logic                 receive_data_ready,
  output logic                      receive_data_valid,
  output logic [DATA_BITS-1:0]      receive_data_buffer,
  output logic                      frame_error_flag,
  output logic                      overrun_pulse
);
  localparam int unsigned W = DATA_BITS + 1;

  typedef struct packed {
    logic                   sync1;
    logic                   sync2;
    logic                   line_prev;
    uarx_pkg::uarx_state_e  state;
    logic [3:0]             smp;
    logic [3:0]             bitn;
    logic [1:0]             votes;
    logic [DATA_BITS-1:0]   shift;
    logic                   push;
    logic [W-1:0]           word;
    logic                   ovr;
    logic                   out_v;
    logic [DATA_BITS-1:0]   out_d;
    logic                   out_fe;
  } uarx_state_s;

  uarx_state_s st_ff, nxt_st;
  uarx_stream_if #(.W(W)) frame_s ();
  logic         buf_valid;
  logic         buf_take;
  logic [W-1:0] buf_data;
  logic [3:0]   vote_first;
  logic [3:0]   last_state;
  logic         in_vote;
  logic         vote_bit;
  logic         end_of_bit;
  logic         line;

  assign frame_s.valid = st_ff.push;
  assign frame_s.data  = st_ff.word;
  // only the second synchroniser stage feeds the sampling logic
  assign line          = st_ff.sync2;

  // rate select; tick is the 16x or 8x sample strobe
  assign vote_first = double_speed_select ? uarx_pkg::VOTE_FIRST_DOUBLE
                                          : uarx_pkg::VOTE_FIRST_NORMAL;
  assign last_state = double_speed_select ? uarx_pkg::LAST_STATE_DOUBLE
                                          : uarx_pkg::LAST_STATE_NORMAL;
  // vote window first, middle and last sample
  assign in_vote    = (st_ff.smp >= vote_first) && (st_ff.smp <= vote_first + 4'h2);
  // two of three high gives one
  assign vote_bit   = (st_ff.votes + 2'(line)) >= 2'h2;
  // last state of a bit; the start bit ends here too, which realigns timing
  assign end_of_bit = (st_ff.smp == last_state);

  uarx_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_s      (frame_s),
    .out_valid (buf_valid),
    .out_ready (buf_take),
    .out_data  (buf_data)
  );

  // output stage holds one word; refilled when empty or consumed
  assign buf_take = buf_valid && (!st_ff.out_v || receive_data_ready);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1     = serial_in;
    nxt_st.sync2     = st_ff.sync1;
    // pulse lasts one enabled clock
    nxt_st.ovr       = 1'b0;
    // one finished frame waits here while the fifo is full, much like
    // the shift register of a classic receiver
    if (frame_s.ready) begin
      nxt_st.push = 1'b0;
    end
    if (st_ff.out_v && receive_data_ready) begin
      nxt_st.out_v = 1'b0;
    end
    if (buf_take) begin
      nxt_st.out_v  = 1'b1;
      nxt_st.out_d  = buf_data[DATA_BITS-1:0];
      nxt_st.out_fe = buf_data[DATA_BITS];
    end
    if (sample_tick) begin
      // edge history kept per sample, not per clock: an edge between
      // two ticks would otherwise be gone before the next tick looks
      nxt_st.line_prev = line;
      case (st_ff.state)
        uarx_pkg::UARX_IDLE: begin
          // falling edge, this low is sample one
          if (st_ff.line_prev && !line) begin
            nxt_st.state = uarx_pkg::UARX_START;
            nxt_st.smp   = uarx_pkg::FIRST_SAMPLE + 4'h1;
            nxt_st.votes = '0;
          end
        end
        uarx_pkg::UARX_START: begin
          nxt_st.smp = st_ff.smp + 4'h1;
          // validation samples counted as high votes
          if (in_vote) begin
            nxt_st.votes = st_ff.votes + 2'(line);
          end
          if (st_ff.smp == vote_first + 4'h2) begin
            if (vote_bit) begin
              nxt_st.state = uarx_pkg::UARX_IDLE;
            end
          end
          if (end_of_bit) begin
            // realign bit counter on the valid start bit
            nxt_st.state = uarx_pkg::UARX_BITS;
            nxt_st.smp   = '0;
            nxt_st.bitn  = '0;
            nxt_st.votes = '0;
          end
        end
        uarx_pkg::UARX_BITS: begin
          nxt_st.smp = st_ff.smp + 4'h1;
          if (in_vote) begin
            nxt_st.votes = st_ff.votes + 2'(line);
          end
          if (st_ff.smp == vote_first + 4'h2) begin
            nxt_st.shift = {vote_bit, st_ff.shift[DATA_BITS-1:1]};
          end
          if (end_of_bit) begin
            nxt_st.smp   = '0;
            nxt_st.votes = '0;
            nxt_st.bitn  = st_ff.bitn + 4'h1;
            // first stop bit only follows the data bits
            if (st_ff.bitn == 4'(DATA_BITS - 1)) begin
              nxt_st.state = uarx_pkg::UARX_STOP;
            end
          end
        end
        uarx_pkg::UARX_STOP: begin
          nxt_st.smp = st_ff.smp + 4'h1;
          if (in_vote) begin
            nxt_st.votes = st_ff.votes + 2'(line);
          end
          if (st_ff.smp == vote_first + 4'h2) begin
            // zero stop bit marks frame error
            nxt_st.word = {!vote_bit, st_ff.shift};
            nxt_st.push = 1'b1;
            // full buffer drops the waiting frame and flags it
            // the waiting frame is replaced by the newer one
            nxt_st.ovr  = st_ff.push && !frame_s.ready;
            // normal mode searches right after the last vote
            // history forced high so a low at the very next sample counts
            if (!double_speed_select) begin
              nxt_st.state     = uarx_pkg::UARX_IDLE;
              nxt_st.line_prev = 1'b1;
            end
          end
          // double speed waits for the full stop bit
          if (end_of_bit && double_speed_select) begin
            nxt_st.state     = uarx_pkg::UARX_IDLE;
            nxt_st.line_prev = 1'b1;
          end
        end
        default: begin
          nxt_st.state = uarx_pkg::UARX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff           <= '0;
      st_ff.sync1     <= 1'b1;
      st_ff.sync2     <= 1'b1;
      st_ff.line_prev <= 1'b1;
      st_ff.state     <= uarx_pkg::UARX_IDLE;
    end else if (clk_en) begin
      // low enable freezes everything, fifo included
      st_ff <= nxt_st;
    end
  end

  assign receive_data_valid  = st_ff.out_v;
  assign receive_data_buffer = st_ff.out_d;
  assign frame_error_flag    = st_ff.out_fe;
  assign overrun_pulse       = st_ff.ovr;
endmodule
`default_nettype wire

/* uarx_pkg.sv */
// shared constants for the asynchronous receive recovery block
`default_nettype none
package uarx_pkg;
  localparam int unsigned SAMPLES_NORMAL = 16;
  localparam int unsigned SAMPLES_DOUBLE = 8;
  localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
  localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
  localparam logic [3:0] LAST_STATE_NORMAL = 4'hf;
  localparam logic [3:0] LAST_STATE_DOUBLE = 4'h7;
  localparam logic [3:0] FIRST_SAMPLE      = 4'h1;
  localparam logic [3:0] DATA_BITS_DEFAULT = 4'h8;
  localparam int unsigned FIFO_DEPTH       = 4;
  typedef enum logic [1:0] {UARX_IDLE, UARX_START, UARX_BITS, UARX_STOP} uarx_state_e;
endpackage
`default_nettype wire

/* uarx_stream_if.sv */
// valid/ready word carrier between receiver core and its buffer
`default_nettype none
interface uarx_stream_if #(parameter int unsigned W = 11);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* uarx_fifo.sv */
// small synchronous fifo for received frames
`default_nettype none
module uarx_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  uarx_stream_if.snk            in_s,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } uarx_fifo_s;
  uarx_fifo_s st_ff, nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_s.ready = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid  = (st_ff.cnt != '0);
  assign out_data   = mem[st_ff.rd];
  assign push = in_s.valid & in_s.ready;
  assign pop  = out_valid & out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : st_ff.wr + AW'(1);
    end
    if (pop) begin
      nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : st_ff.rd + AW'(1);
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      if (push) begin
        mem[st_ff.wr] <= in_s.data;
      end
    end
  end
endmodule
`default_nettype wire

/* uarx_recovery_monitor.sv */
// port-level checker for the receive recovery block
`default_nettype none
module uarx_recovery_monitor #(
  parameter int unsigned DATA_BITS = 8
) (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic                 clk_en,
  input wire logic                 receive_data_ready,
  input wire logic                 receive_data_valid,
  input wire logic [DATA_BITS-1:0] receive_data_buffer,
  input wire logic                 frame_error_flag,
  input wire logic                 overrun_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_held;
    receive_data_valid && !receive_data_ready;
  endsequence
  sequence s_quiet;
    !receive_data_valid [*8];
  endsequence
  AST_VALID_HOLD: assert property (s_held |=> receive_data_valid)
    else $error("word dropped before accept");
  AST_DATA_HOLD: assert property (s_held |=> $stable(receive_data_buffer))
    else $error("data changed while held");
  AST_FE_HOLD: assert property (s_held |=> $stable(frame_error_flag))
    else $error("error flag changed while held");
  AST_RST_CLEAR: assert property ($fell(rst) |-> !frame_error_flag && !overrun_pulse)
    else $error("outputs not cleared by reset");
  AST_NO_WORD_AFTER_RST: assert property ($fell(rst) |-> s_quiet)
    else $error("word without any start bit");
  AST_OVR_ONE: assert property (overrun_pulse |=> !overrun_pulse)
    else $error("overrun longer than one cycle");
  AST_OVR_FULL: assert property (overrun_pulse |-> $past(receive_data_valid))
    else $error("overrun while output empty");
  AST_FREEZE: assert property (!clk_en |=>
    $stable({receive_data_valid, receive_data_buffer}))
    else $error("outputs moved while disabled");
endmodule
bind uarx_recovery uarx_recovery_monitor #(.DATA_BITS(DATA_BITS)) uarx_recovery_monitor_i (
  .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .receive_data_ready(receive_data_ready),
  .receive_data_valid(receive_data_valid), .receive_data_buffer(receive_data_buffer),
  .frame_error_flag(frame_error_flag), .overrun_pulse(overrun_pulse));
`default_nettype wire

/* uarx_tx_model.sv */
// remote asynchronous transmitter on the receive line
`default_nettype none
module uarx_tx_model (
  input  wire logic core_clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle line rests high between frames
  initial line = 1'b1;
  task automatic hold(input logic v, input int clks);
    line = v;
    repeat (clks) @(negedge core_clk);
  endtask
  task automatic send(input logic [7:0] d, input logic stop, input int bit_clks);
    hold(1'b0, bit_clks);
    for (int i = 0; i < 8; i++)
      hold(d[i], bit_clks);
    hold(stop, bit_clks);
    line = 1'b1;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the receive recovery block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       clk_en = 1'b1;
  logic       sample_tick = 1'b0;
  logic       double_speed_select = 1'b0;
  logic       receive_data_ready = 1'b0;
  logic       serial_in;
  logic       receive_data_valid;
  logic [7:0] receive_data_buffer;
  logic       frame_error_flag;
  logic       overrun_pulse;
  int         failures = 0;
  int         checks = 0;
  int         cycles = 0;
  int         ovr_seen = 0;
  always #4 core_clk = ~core_clk;
  // one tick every 4 clocks: 64 clocks a bit normal, 32 double
  always @(negedge core_clk) sample_tick <= (cycles % 4 == 0);
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (overrun_pulse === 1'b1) ovr_seen <= ovr_seen + 1;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end
  uarx_recovery uarx_recovery_i (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .sample_tick(sample_tick), .double_speed_select(double_speed_select),
    .serial_in(serial_in), .receive_data_ready(receive_data_ready),
    .receive_data_valid(receive_data_valid), .receive_data_buffer(receive_data_buffer),
    .frame_error_flag(frame_error_flag), .overrun_pulse(overrun_pulse));
  uarx_tx_model uarx_tx_model_i (.core_clk(core_clk), .line(serial_in));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // waits for a word, compares valid, flag and data, then accepts it
  task automatic get_word(input logic [8:0] exp);
    int n;
    n = 0;
    while (receive_data_valid !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk({receive_data_valid, frame_error_flag, receive_data_buffer}, {1'b1, exp});
    receive_data_ready = 1'b1;
    @(negedge core_clk);
    receive_data_ready = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic t_normal();
    uarx_tx_model_i.send(8'ha5, 1'b1, 64);
    uarx_tx_model_i.send(8'h3c, 1'b1, 64);
    get_word(9'h0a5);
    get_word(9'h03c);
  endtask
  task automatic t_frame_err();
    uarx_tx_model_i.send(8'h5a, 1'b0, 64);
    uarx_tx_model_i.hold(1'b1, 64);
    uarx_tx_model_i.send(8'h81, 1'b1, 64);
    get_word(9'h15a);
    get_word(9'h081);
  endtask
  task automatic t_noise();
    // low for exactly samples one to eight: two of three votes high
    uarx_tx_model_i.hold(1'b0, 32);
    uarx_tx_model_i.hold(1'b1, 1200);
    chk({9'h0, receive_data_valid}, 10'h0);
  endtask
  task automatic t_double();
    double_speed_select = 1'b1;
    uarx_tx_model_i.send(8'h96, 1'b1, 32);
    uarx_tx_model_i.send(8'h69, 1'b1, 32);
    get_word(9'h096);
    get_word(9'h069);
    double_speed_select = 1'b0;
  endtask
  task automatic t_reset();
    uarx_tx_model_i.send(8'he7, 1'b0, 64);
    uarx_tx_model_i.hold(1'b1, 64);
    chk({8'h0, receive_data_valid, frame_error_flag}, 10'h3);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk({8'h0, receive_data_valid, frame_error_flag}, 10'h0);
    repeat (4) @(negedge core_clk);
    uarx_tx_model_i.send(8'h7e, 1'b1, 64);
    get_word(9'h07e);
  endtask
  task automatic t_overrun();
    // five words fill output and fifo, the sixth waits, the seventh overruns
    for (int i = 0; i < 7; i++)
      uarx_tx_model_i.send(8'(i * 19), 1'b1, 64);
    chk(10'(ovr_seen), 10'h1);
    clk_en = 1'b0;
    receive_data_ready = 1'b1;
    repeat (3) @(negedge core_clk);
    receive_data_ready = 1'b0;
    clk_en = 1'b1;
    // the sixth frame was the one replaced by the seventh
    for (int i = 0; i < 7; i++)
      if (i != 5) get_word({1'b0, 8'(i * 19)});
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_normal();
    t_frame_err();
    t_noise();
    t_double();
    t_reset();
    t_overrun();
    finish_test();
  end
endmodule
`default_nettype wire
